// ==== verilog/clock_ctrl_pkg.sv ====
// constants and types for the peripheral clock gate and divider block
package clock_ctrl_pkg;

    localparam logic [31:0] gate_addr        = 32'h4004_8080;
    localparam logic [31:0] ssp_div_addr     = 32'h4004_8094;
    localparam logic [31:0] uart_div_addr    = 32'h4004_8098;
    localparam logic [31:0] trace_div_addr   = 32'h4004_80ac;
    localparam logic [31:0] tick_div_addr    = 32'h4004_80b0;
    localparam logic [31:0] usb_sel_addr     = 32'h4004_80c0;
    localparam logic [31:0] usb_upd_addr     = 32'h4004_80c4;
    localparam logic [31:0] usb_div_addr     = 32'h4004_80c8;
    localparam logic [31:0] wdt_sel_addr     = 32'h4004_80d0;
    localparam logic [31:0] wdt_upd_addr     = 32'h4004_80d4;

    localparam int          gate_usb_reg_bit = 14;
    localparam int          gate_wdt_bit     = 15;
    localparam int          gate_pin_cfg_bit = 16;
    localparam int          gate_width       = 17;
    localparam logic [16:0] gate_reset       = 17'h0_40ff;

    localparam logic [7:0]  ssp_div_reset    = 8'h01;
    localparam logic [7:0]  uart_div_reset   = 8'h00;
    localparam logic [7:0]  trace_div_reset  = 8'h00;
    localparam logic [7:0]  tick_div_reset   = 8'h00;
    localparam logic [7:0]  usb_div_reset    = 8'h01;
    localparam logic [1:0]  usb_sel_reset    = 2'h0;
    localparam logic [1:0]  wdt_sel_reset    = 2'h0;
    localparam logic        upd_reset        = 1'h0;

    localparam logic [1:0]  usb_src_pll      = 2'h0;
    localparam logic [1:0]  usb_src_main     = 2'h1;

    typedef struct packed {
        logic usb_reg;
        logic wdt;
        logic pin_config;
    } clock_gate_s;

    typedef struct packed {
        logic ssp;
        logic uart;
        logic trace;
        logic tick_timer;
        logic usb;
    } clock_tick_s;

endpackage

// ==== verilog/tick_divider.sv ====
// divide a source tick stream by an 8-bit value, 0 stops the output
`timescale 1ns/1ps
module tick_divider (
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       src_tick_i,
    input  wire logic [7:0] div_i,
    output logic            boundary_o,
    output logic            tick_o
);
    logic [7:0] cnt_r;
    logic [7:0] cur_div_r;
    logic       at_end;

    // a stopped divider counts as at its boundary on every source tick
    assign at_end     = (cur_div_r == 8'h00) || (cnt_r >= cur_div_r - 8'h01);
    assign boundary_o = src_tick_i && at_end;

    // new divisor only loads at a period end: no shortened pulse
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r     <= 8'h00;
            cur_div_r <= 8'h00;
            tick_o    <= 1'b0;
        end else if (boundary_o) begin
            cnt_r     <= 8'h00;
            cur_div_r <= div_i;
            tick_o    <= (cur_div_r != 8'h00);
        end else begin
            cnt_r     <= src_tick_i ? cnt_r + 8'h01 : cnt_r;
            tick_o    <= 1'b0;
        end
    end
endmodule

// ==== verilog/peripheral_clock_gate_divide.sv ====
// register file, gates and dividers for peripheral clocks
`timescale 1ns/1ps
module peripheral_clock_gate_divide (
    input  wire logic                        sys_clk_i,
    input  wire logic                        resetn_i,
    input  wire logic                        usb_pll_clk_i,
    input  wire logic [31:0]                 address_i,
    input  wire logic                        read_i,
    input  wire logic                        write_i,
    input  wire logic [31:0]                 writedata_i,
    output logic [31:0]                      readdata_o,
    output logic                             waitrequest_o,
    output clock_ctrl_pkg::clock_gate_s      gate_o,
    output clock_ctrl_pkg::clock_tick_s      tick_o,
    output logic [1:0]                       usb_src_o,
    output logic [1:0]                       wdt_src_o
);
    import clock_ctrl_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [gate_width-1:0] gate_r;
    logic [7:0]            ssp_div_r;
    logic [7:0]            uart_div_r;
    logic [7:0]            trace_div_r;
    logic [7:0]            tick_div_r;
    logic [7:0]            usb_div_r;
    logic [1:0]            usb_sel_r;
    logic [1:0]            wdt_sel_r;
    logic                  usb_upd_r;
    logic                  wdt_upd_r;
    logic                  usb_pend_r;
    logic [1:0]            pll_sync_r;
    logic                  pll_prev_r;
    logic                  take;
    logic                  wr_take;
    logic                  wr_gate;
    logic                  wr_ssp_div;
    logic                  wr_uart_div;
    logic                  wr_trace_div;
    logic                  wr_tick_div;
    logic                  wr_usb_div;
    logic                  wr_usb_sel;
    logic                  wr_wdt_sel;
    logic                  usb_rise;
    logic                  wdt_rise;
    logic                  pll_tick;
    logic                  usb_src_tick;
    logic                  usb_boundary;
    logic [31:0]           rd_mux;
    clock_tick_s           div_tick;

    // ****************************************
    // avalon slave
    // ****************************************
    // one wait cycle: data is ready at the edge that drops waitrequest
    assign take    = (read_i || write_i) && !waitrequest_o;
    assign wr_take = take && write_i;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            waitrequest_o <= 1'b1;
        end else begin
            waitrequest_o <= !((read_i || write_i) && waitrequest_o);
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (address_i)
            gate_addr:      rd_mux = {15'h0000, gate_r};
            ssp_div_addr:   rd_mux = {24'h00_0000, ssp_div_r};
            uart_div_addr:  rd_mux = {24'h00_0000, uart_div_r};
            trace_div_addr: rd_mux = {24'h00_0000, trace_div_r};
            tick_div_addr:  rd_mux = {24'h00_0000, tick_div_r};
            usb_sel_addr:   rd_mux = {30'h0000_0000, usb_sel_r};
            usb_upd_addr:   rd_mux = {31'h0000_0000, usb_upd_r};
            usb_div_addr:   rd_mux = {24'h00_0000, usb_div_r};
            wdt_sel_addr:   rd_mux = {30'h0000_0000, wdt_sel_r};
            wdt_upd_addr:   rd_mux = {31'h0000_0000, wdt_upd_r};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // unmapped reads answer zero, unmapped writes are dropped
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            readdata_o <= 32'h0000_0000;
        end else if (read_i && waitrequest_o) begin
            readdata_o <= rd_mux;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // one decoded strobe per register keeps each block to its own concern
    assign wr_gate      = wr_take && (address_i == gate_addr);
    assign wr_ssp_div   = wr_take && (address_i == ssp_div_addr);
    assign wr_uart_div  = wr_take && (address_i == uart_div_addr);
    assign wr_trace_div = wr_take && (address_i == trace_div_addr);
    assign wr_tick_div  = wr_take && (address_i == tick_div_addr);
    assign wr_usb_div   = wr_take && (address_i == usb_div_addr);
    assign wr_usb_sel   = wr_take && (address_i == usb_sel_addr);
    assign wr_wdt_sel   = wr_take && (address_i == wdt_sel_addr);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gate_r <= gate_reset;
        end else if (wr_gate) begin
            gate_r <= writedata_i[gate_width-1:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ssp_div_r <= ssp_div_reset;
        end else if (wr_ssp_div) begin
            ssp_div_r <= writedata_i[7:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            uart_div_r <= uart_div_reset;
        end else if (wr_uart_div) begin
            uart_div_r <= writedata_i[7:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trace_div_r <= trace_div_reset;
        end else if (wr_trace_div) begin
            trace_div_r <= writedata_i[7:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_div_r <= tick_div_reset;
        end else if (wr_tick_div) begin
            tick_div_r <= writedata_i[7:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            usb_div_r <= usb_div_reset;
        end else if (wr_usb_div) begin
            usb_div_r <= writedata_i[7:0];
        end
    end

    // stored code is not yet the applied one: see update strobes
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            usb_sel_r <= usb_sel_reset;
        end else if (wr_usb_sel) begin
            usb_sel_r <= writedata_i[1:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wdt_sel_r <= wdt_sel_reset;
        end else if (wr_wdt_sel) begin
            wdt_sel_r <= writedata_i[1:0];
        end
    end

    // ****************************************
    // update strobes
    // ****************************************
    // only a 0 to 1 change of the stored bit applies a selection
    assign usb_rise = wr_take && (address_i == usb_upd_addr)
                      && writedata_i[0] && !usb_upd_r;
    assign wdt_rise = wr_take && (address_i == wdt_upd_addr)
                      && writedata_i[0] && !wdt_upd_r;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            usb_upd_r <= upd_reset;
        end else if (wr_take && address_i == usb_upd_addr) begin
            usb_upd_r <= writedata_i[0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wdt_upd_r <= upd_reset;
        end else if (wr_take && address_i == wdt_upd_addr) begin
            wdt_upd_r <= writedata_i[0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wdt_src_o <= wdt_sel_reset;
        end else if (wdt_rise) begin
            wdt_src_o <= wdt_sel_r;
        end
    end

    // ****************************************
    // usb source switch
    // ****************************************
    // a request arriving at the boundary cycle stays pending: set wins
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            usb_pend_r <= 1'b0;
        end else if (usb_rise) begin
            usb_pend_r <= 1'b1;
        end else if (usb_boundary || usb_div_r == 8'h00) begin
            usb_pend_r <= 1'b0;
        end
    end

    // switch only between output periods so no short usb pulse appears
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            usb_src_o <= usb_sel_reset;
        end else if (usb_pend_r && !usb_rise
                     && (usb_boundary || usb_div_r == 8'h00)) begin
            usb_src_o <= usb_sel_r;
        end
    end

    // pll input comes from another clock: two flops, then edge detect
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pll_sync_r <= 2'h0;
            pll_prev_r <= 1'b0;
        end else begin
            pll_sync_r <= {pll_sync_r[0], usb_pll_clk_i};
            pll_prev_r <= pll_sync_r[1];
        end
    end

    // limitation: pll faster than half sys_clk aliases in this sampling
    assign pll_tick = pll_sync_r[1] && !pll_prev_r;

    // reserved codes give no source ticks at all
    always_comb begin
        unique case (usb_src_o)
            usb_src_pll:  usb_src_tick = pll_tick;
            usb_src_main: usb_src_tick = 1'b1;
            default:      usb_src_tick = 1'b0;
        endcase
    end

    // ****************************************
    // dividers
    // ****************************************
    tick_divider u_ssp_div (
        .sys_clk_i  (sys_clk_i),
        .resetn_i   (resetn_i),
        .src_tick_i (1'b1),
        .div_i      (ssp_div_r),
        .boundary_o (),
        .tick_o     (div_tick.ssp)
    );

    tick_divider u_uart_div (
        .sys_clk_i  (sys_clk_i),
        .resetn_i   (resetn_i),
        .src_tick_i (1'b1),
        .div_i      (uart_div_r),
        .boundary_o (),
        .tick_o     (div_tick.uart)
    );

    tick_divider u_trace_div (
        .sys_clk_i  (sys_clk_i),
        .resetn_i   (resetn_i),
        .src_tick_i (1'b1),
        .div_i      (trace_div_r),
        .boundary_o (),
        .tick_o     (div_tick.trace)
    );

    tick_divider u_tick_div (
        .sys_clk_i  (sys_clk_i),
        .resetn_i   (resetn_i),
        .src_tick_i (1'b1),
        .div_i      (tick_div_r),
        .boundary_o (),
        .tick_o     (div_tick.tick_timer)
    );

    tick_divider u_usb_div (
        .sys_clk_i  (sys_clk_i),
        .resetn_i   (resetn_i),
        .src_tick_i (usb_src_tick),
        .div_i      (usb_div_r),
        .boundary_o (usb_boundary),
        .tick_o     (div_tick.usb)
    );

    // divider ticks already come from flops
    assign tick_o = div_tick;

    // ****************************************
    // gate outputs
    // ****************************************
    always_comb begin
        gate_o.usb_reg    = gate_r[gate_usb_reg_bit];
        gate_o.wdt        = gate_r[gate_wdt_bit];
        gate_o.pin_config = gate_r[gate_pin_cfg_bit];
    end

endmodule

// ==== tb/clock_ctrl_checker.sv ====
// assertion checker for the peripheral clock gate and divider block
`timescale 1ns/1ps
module clock_ctrl_checker (
    input wire logic                        sys_clk_i,
    input wire logic                        resetn_i,
    input wire logic [31:0]                 address_i,
    input wire logic                        read_i,
    input wire logic                        write_i,
    input wire logic [31:0]                 writedata_i,
    input wire logic [31:0]                 readdata_o,
    input wire logic                        waitrequest_o,
    input wire clock_ctrl_pkg::clock_gate_s gate_o,
    input wire clock_ctrl_pkg::clock_tick_s tick_o,
    input wire logic [1:0]                  usb_src_o,
    input wire logic [1:0]                  wdt_src_o
);
    import clock_ctrl_pkg::*;
    logic       tk, wtk, wev, uev;
    logic       div_w_r, wupd_r, uupd_r, upend_r;
    logic [1:0] wsel_r, usrc_r;
    assign tk  = (read_i | write_i) & ~waitrequest_o;
    assign wtk = tk & write_i;
    assign wev = wtk & (address_i == wdt_upd_addr) & writedata_i[0] & ~wupd_r;
    assign uev = wtk & (address_i == usb_upd_addr) & writedata_i[0] & ~uupd_r;
    // pending stays set if the applied code equals the old one: weaker, never false
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_w_r <= 1'b0;
            wupd_r  <= 1'b0;
            uupd_r  <= 1'b0;
            upend_r <= 1'b0;
            wsel_r  <= 2'h0;
            usrc_r  <= 2'h0;
        end else begin
            if (wtk && (address_i == uart_div_addr || address_i == trace_div_addr
                        || address_i == tick_div_addr)) div_w_r <= 1'b1;
            if (wtk && address_i == wdt_upd_addr) wupd_r <= writedata_i[0];
            if (wtk && address_i == wdt_sel_addr) wsel_r <= writedata_i[1:0];
            if (wtk && address_i == usb_upd_addr) uupd_r <= writedata_i[0];
            upend_r <= uev | (upend_r & (usb_src_o == usrc_r));
            usrc_r  <= usb_src_o;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_wait; (read_i | write_i) && waitrequest_o |=> !waitrequest_o; endproperty
    a_wait: assert property (p_wait) else $error("no answer one cycle after request");
    property p_gate; wtk && address_i == gate_addr |=> gate_o ==
        {$past(writedata_i[gate_usb_reg_bit]), $past(writedata_i[gate_wdt_bit]),
         $past(writedata_i[gate_pin_cfg_bit])}; endproperty
    a_gate: assert property (p_gate) else $error("gate outputs differ");
    property p_rsv_gate; tk && read_i && address_i == gate_addr |-> readdata_o[31:17] == 15'h0;
    endproperty
    a_rsv_gate: assert property (p_rsv_gate) else $error("gate upper bits not zero");
    property p_rsv_upd; tk && read_i && address_i == usb_upd_addr |-> readdata_o[31:1] == 31'h0;
    endproperty
    a_rsv_upd: assert property (p_rsv_upd) else $error("update upper bits not zero");
    property p_off; !div_w_r |-> !(tick_o.uart | tick_o.trace | tick_o.tick_timer); endproperty
    a_off: assert property (p_off) else $error("stopped clock ticks after reset");
    property p_wdt_apply; wev |=> wdt_src_o == $past(wsel_r); endproperty
    a_wdt_apply: assert property (p_wdt_apply) else $error("wdt source not applied");
    property p_wdt_hold; !wev |=> $stable(wdt_src_o); endproperty
    a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog source moved");
    property p_usb_hold; !upend_r && !uev |=> $stable(usb_src_o); endproperty
    a_usb_hold: assert property (p_usb_hold) else $error("usb source moved unasked");
endmodule
bind peripheral_clock_gate_divide clock_ctrl_checker i_clock_ctrl_checker (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .gate_o(gate_o), .tick_o(tick_o),
    .usb_src_o(usb_src_o), .wdt_src_o(wdt_src_o));

// ==== tb/periph_model.sv ====
// far-side model: free-running usb pll source and tick counters
`timescale 1ns/1ps
module periph_model (
    input  wire logic                        sys_clk_i,
    input  wire logic                        clr_i,
    input  wire clock_ctrl_pkg::clock_tick_s tick_i,
    output logic                             usb_pll_clk_o,
    output logic [4:0][15:0]                 cnt_o
);
    import clock_ctrl_pkg::*;
    // period of four system cycles keeps counts exact over whole windows
    initial begin
        usb_pll_clk_o = 1'b0;
        #13;
        forever #100 usb_pll_clk_o = ~usb_pll_clk_o;
    end
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < 5; i++) begin
            cnt_o[i] <= clr_i ? 16'h0 : cnt_o[i] + 16'(tick_i[i]);
        end
    end
endmodule

// ==== tb/tb.sv ====
// testbench for the peripheral clock gate and divider block
`timescale 1ns/1ps
module tb;
    import clock_ctrl_pkg::*;
    logic              sys_clk, resetn, pll_clk, rd, wr, wait_req, clr;
    logic [31:0]       addr, wdata, rdata, v;
    clock_gate_s       gate;
    clock_tick_s       tick;
    logic [1:0]        usb_src, wdt_src;
    logic [4:0][15:0]  cnt;
    int                err_count = 0;
    int                checks_done = 0;
    logic [31:0]       regs [4] = '{ssp_div_addr, uart_div_addr, trace_div_addr, tick_div_addr};
    logic [7:0]        divs [4] = '{8'h00, 8'h01, 8'h05, 8'hff};
    peripheral_clock_gate_divide i_peripheral_clock_gate_divide (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .usb_pll_clk_i(pll_clk), .address_i(addr),
        .read_i(rd), .write_i(wr), .writedata_i(wdata), .readdata_o(rdata),
        .waitrequest_o(wait_req), .gate_o(gate), .tick_o(tick), .usb_src_o(usb_src),
        .wdt_src_o(wdt_src));
    periph_model i_periph_model (.sys_clk_i(sys_clk), .clr_i(clr), .tick_i(tick),
        .usb_pll_clk_o(pll_clk), .cnt_o(cnt));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ****************************************
    // bus access and compare tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // holds the request until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (n >= 50) err_count++;
        v = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(v, e);
    endtask
    // window is a multiple of every period used, so counts are exact
    task automatic meas(input int i, input logic [15:0] e);
        repeat (600) @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (1020) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(32'(cnt[i]), 32'(e));
    endtask
    task automatic usb_sw(input logic [1:0] s);
        bus(1'b1, usb_sel_addr, {30'h0, s});
        bus(1'b1, usb_upd_addr, 32'h0);
        bus(1'b1, usb_upd_addr, 32'h1);
        repeat (5) @(negedge sys_clk);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge sys_clk);
        err_count++;
        test_done();
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        resetn = 1'b0; rd = 1'b0; wr = 1'b0; addr = 32'h0; wdata = 32'h0; clr = 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        rchk(gate_addr, 32'h0000_40ff);
        chk(32'(gate), 32'h4);
        rchk(usb_sel_addr, 32'h0);
        rchk(usb_upd_addr, 32'h0);
        rchk(usb_div_addr, 32'h01);
        meas(4, 16'd1020);
        meas(3, 16'd0);
        bus(1'b1, 32'h4004_8090, 32'hffff_ffff);
        rchk(32'h4004_8090, 32'h0);
        bus(1'b1, gate_addr, 32'hffff_ffff);
        rchk(gate_addr, 32'h0001_ffff);
        chk(32'(gate), 32'h7);
        bus(1'b1, gate_addr, 32'h0001_0000);
        chk(32'(gate), 32'h1);
        foreach (regs[r]) begin
            rchk(regs[r], r == 0 ? 32'h1 : 32'h0);
            foreach (divs[k]) begin
                bus(1'b1, regs[r], {24'hff_ffff, divs[k]});
                rchk(regs[r], {24'h0, divs[k]});
                meas(4 - r, divs[k] == 8'h0 ? 16'd0 : 16'(1020 / divs[k]));
            end
        end
        meas(0, 16'd255);
        bus(1'b1, usb_sel_addr, 32'h1);
        meas(0, 16'd255);
        usb_sw(2'h1);
        meas(0, 16'd1020);
        bus(1'b1, usb_div_addr, 32'h5);
        meas(0, 16'd204);
        bus(1'b1, usb_div_addr, 32'h0);
        meas(0, 16'd0);
        usb_sw(2'h2);
        chk(32'(usb_src), 32'h2);
        bus(1'b1, usb_sel_addr, 32'h1);
        bus(1'b1, usb_upd_addr, 32'h1);
        repeat (5) @(negedge sys_clk);
        chk(32'(usb_src), 32'h2);
        rchk(usb_upd_addr, 32'h1);
        usb_sw(2'h1);
        chk(32'(usb_src), 32'h1);
        bus(1'b1, usb_div_addr, 32'h1);
        usb_sw(2'h0);
        meas(0, 16'd255);
        chk(32'(usb_src), 32'h0);
        bus(1'b1, wdt_sel_addr, 32'h2);
        chk(32'(wdt_src), 32'h0);
        bus(1'b1, wdt_upd_addr, 32'h0);
        bus(1'b1, wdt_upd_addr, 32'h1);
        chk(32'(wdt_src), 32'h2);
        bus(1'b1, wdt_sel_addr, 32'h1);
        bus(1'b1, wdt_upd_addr, 32'h1);
        chk(32'(wdt_src), 32'h2);
        rchk(wdt_upd_addr, 32'h1);
        test_done();
    end
endmodule
